// ===== ata_idle_init_read_cmds.sv
// ata command executor for idle immediate, init parameters, nop, read buffer,
// dma read and multiple-sector read, with a word fifo toward the host
// assumes task-file writes and media words are synchronous to clk
//
// Behaviour
// - idle immediate: busy, enter idle power state, drop busy, interrupt
// - init parameters stores sectors per track and heads from count and head select
// - nop always ends as an aborted command
// - read buffer returns sector buffer contents with single-sector pio handshake
// - dma read moves 1 to 256 sectors, count zero meaning 256
// - dma read holds busy while the buffer fills
// - dmarq is high whenever dma read data waits for the host
// - dma read interrupts only at the end or on error
// - dma read aborts while byte-wide transfer mode is enabled
// - multiple read sends blocks with one interrupt each, drq only at block start
// - count is in sectors: full blocks, then a partial block of the rest
// - multiple read takes 1 to 256 sectors, zero meaning 256
// - multiple read aborts if block size unset or multiple reads disabled
// - media error posts when the failing sector loads; the block is still transferred
// - multiple read interrupts at each drq set for a block
// - on read error keep the failing sector's address; dma stops there with its data, multiple read ends its block
// - only corrected errors let later blocks follow
// - reads start at the task-file address; lba uses head, cyl and sector fields
// - between pio blocks: busy, load sector, drq, drop busy, interrupt
`timescale 1ns/1ns

// word fifo between sector buffer and host; depth must be a power of two
module sync_fifo
  import ata_cmd_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,      // system clock
  input  wire logic             rst,      // async reset, high
  input  wire logic             inValid,  // write side offers a word
  output logic                  inReady,  // room for a word
  input  wire logic [WIDTH-1:0] inData,   // word in
  output logic                  outValid, // a word is held
  input  wire logic             outReady, // read side takes the word
  output logic      [WIDTH-1:0] outData   // head word
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0]   cnt;
  } fifo_st_t;

  fifo_st_t         s_reg;
  fifo_st_t         s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // honest full and empty from the fill count
  assign inReady  = (s_reg.cnt != FULL_CNT);
  assign outValid = (s_reg.cnt != '0);
  assign outData  = mem[s_reg.rd];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // pointer and count update
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.wr = s_reg.wr + 1'b1;
    end
    if (pop) begin
      s_next.rd = s_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_reg.wr] <= inData;
    end
  end
endmodule : sync_fifo

module ata_idle_init_read_cmds
  import ata_cmd_pkg::*;
(
  input  wire logic              clk,             // 50 MHz system clock
  input  wire logic              rst,             // async reset, high
  input  wire logic              cmdStrobe,       // command register written
  input  wire logic [7:0]        cmdCode,         // command code
  input  wire taskfile_t         taskIn,          // command block registers
  input  wire logic              statusRd,        // host read status, clears intrq
  input  wire logic              hostRd,          // pio data register read
  output logic [WORD_W-1:0]      hostData,        // data word for host
  input  wire logic              dmackN,          // dma acknowledge, low
  input  wire logic              iordN,           // io read strobe, low
  output logic                   dmarq,           // dma request
  input  wire logic              byteModeEn,      // 8-bit transfer enabled
  input  wire logic              multipleEnabled, // multiple reads allowed
  input  wire logic [7:0]        blockSize,       // sectors per block, 0 unset
  output logic                   mediaReq,        // fetch sector at taskOut
  input  wire logic              mediaValid,      // media word valid
  output logic                   mediaReady,      // media word accepted
  input  wire logic [WORD_W-1:0] mediaData,       // media word
  input  wire logic              mediaErr,        // error, with last word
  input  wire logic              mediaErrCorr,    // error was corrected
  output status_t                status,          // host status bits
  output logic [7:0]             errorReg,        // error register
  output taskfile_t              taskOut,         // current address
  output logic                   idleMode,        // idle power state
  output logic [7:0]             sectorsPerTrack, // stored geometry
  output logic [HEAD_W-1:0]      maxHead          // stored heads minus one
);
  typedef struct packed {
    state_t            state;
    xfer_t             mode;
    taskfile_t         tf;
    status_t           stat;
    logic [7:0]        errReg;
    logic [8:0]        secLeft;
    logic [8:0]        blkLeft;
    logic [7:0]        wordCnt;
    logic              reqIssued;
    logic              stopReq;
    logic              blockStart;
    logic              iordPrev;
    logic              mediaReq;
    logic [WORD_W-1:0] hostData;
    logic              idle;
    logic [7:0]        spt;
    logic [HEAD_W-1:0] maxHead;
  } st_t;

  st_t               s_reg;
  st_t               s_next;
  logic [WORD_W-1:0] secBuf [256];
  logic              fifoInValid;
  logic              fifoInReady;
  logic              fifoOutValid;
  logic              fifoOutReady;
  logic [WORD_W-1:0] fifoOutData;
  logic              push;
  logic              pop;
  logic              mediaTake;
  logic              popDma;
  logic [8:0]        reqTotal;
  logic [8:0]        blkSz;

  // next sector address, lba or chs
  function automatic taskfile_t next_addr(input taskfile_t t, input logic [7:0] spt,
                                          input logic [HEAD_W-1:0] mh);
    taskfile_t   r;
    logic [27:0] lba;
    r   = t;
    lba = {t.devHead[HEAD_W-1:0], t.cylHigh, t.cylLow, t.sector} + 28'h0000001;
    if (t.devHead[DH_LBA_BIT]) begin
      {r.devHead[HEAD_W-1:0], r.cylHigh, r.cylLow, r.sector} = lba;
    end else if (t.sector != spt) begin
      r.sector = t.sector + 8'h01;
    end else begin
      r.sector = CHS_FIRST_SEC;
      if (t.devHead[HEAD_W-1:0] != mh) begin
        r.devHead[HEAD_W-1:0] = t.devHead[HEAD_W-1:0] + 4'h1;
      end else begin
        r.devHead[HEAD_W-1:0] = '0;
        {r.cylHigh, r.cylLow} = {t.cylHigh, t.cylLow} + 16'h0001;
      end
    end
    return r;
  endfunction : next_addr

  // requested count and block size
  assign reqTotal = (taskIn.count == 8'h00) ? MAX_SECTORS : {1'b0, taskIn.count};
  assign blkSz    = {1'b0, blockSize};

  // data path handshakes
  assign mediaReady   = (s_reg.state == ST_LOAD) && s_reg.reqIssued;
  assign mediaTake    = mediaReady && mediaValid;
  assign fifoInValid  = (s_reg.state == ST_COPY);
  assign push         = fifoInValid && fifoInReady;
  assign popDma       = !dmackN && s_reg.iordPrev && !iordN;
  assign fifoOutReady = (s_reg.mode == XF_DMA) ? popDma : (s_reg.stat.drq && hostRd);
  assign pop          = fifoOutValid && fifoOutReady;
  assign dmarq        = (s_reg.mode == XF_DMA) && fifoOutValid;

  // register outputs
  assign hostData        = s_reg.hostData;
  assign mediaReq        = s_reg.mediaReq;
  assign status          = s_reg.stat;
  assign errorReg        = s_reg.errReg;
  assign taskOut         = s_reg.tf;
  assign idleMode        = s_reg.idle;
  assign sectorsPerTrack = s_reg.spt;
  assign maxHead         = s_reg.maxHead;

  sync_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (secBuf[s_reg.wordCnt]),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // command sequencer
  always_comb begin
    s_next          = s_reg;
    s_next.iordPrev = iordN;
    s_next.mediaReq = 1'b0;
    if (pop) begin
      s_next.hostData = fifoOutData;
    end
    if (statusRd) begin
      s_next.stat.intrq = 1'b0;
    end
    case (s_reg.state)
      ST_READY: begin
        if (cmdStrobe) begin
          s_next.stat      = '0;
          s_next.errReg    = '0;
          s_next.wordCnt   = '0;
          s_next.reqIssued = 1'b0;
          s_next.stopReq   = 1'b0;
          s_next.tf        = taskIn;
          case (cmdCode)
            CMD_IDLE_IMM_A, CMD_IDLE_IMM_B: begin
              s_next.stat.bsy = 1'b1;
              s_next.state    = ST_POWER;
            end
            CMD_INIT_PARAMS: begin
              s_next.tf                = s_reg.tf;
              s_next.spt               = taskIn.count;
              s_next.maxHead           = taskIn.devHead[HEAD_W-1:0];
              s_next.stat.intrq        = 1'b1;
            end
            CMD_READ_BUF: begin
              s_next.tf         = s_reg.tf;
              s_next.mode       = XF_PIO1;
              s_next.secLeft    = ONE_SECTOR;
              s_next.blkLeft    = ONE_SECTOR;
              s_next.stat.bsy   = 1'b1;
              s_next.blockStart = 1'b1;
              s_next.state      = ST_COPY;
            end
            CMD_READ_DMA, CMD_READ_MULT: begin
              if ((cmdCode == CMD_READ_DMA && byteModeEn) ||
                  (cmdCode == CMD_READ_MULT && (!multipleEnabled || blockSize == 8'h00))) begin
                s_next.tf                   = s_reg.tf;
                s_next.stat.err             = 1'b1;
                s_next.errReg[ERR_ABRT_BIT] = 1'b1;
                s_next.stat.intrq           = 1'b1;
              end else begin
                s_next.mode       = (cmdCode == CMD_READ_DMA) ? XF_DMA : XF_MULT;
                s_next.secLeft    = reqTotal;
                s_next.blkLeft    = (cmdCode == CMD_READ_DMA || blkSz > reqTotal)
                                    ? reqTotal : blkSz;
                s_next.stat.bsy   = 1'b1;
                s_next.blockStart = 1'b1;
                s_next.idle       = 1'b0;
                s_next.state      = ST_LOAD;
              end
            end
            default: begin
              s_next.tf                   = s_reg.tf;
              s_next.stat.err             = 1'b1;
              s_next.errReg[ERR_ABRT_BIT] = 1'b1;
              s_next.stat.intrq           = 1'b1;
            end
          endcase
        end
      end
      ST_POWER: begin
        s_next.idle       = 1'b1;
        s_next.stat.bsy   = 1'b0;
        s_next.stat.intrq = 1'b1;
        s_next.state      = ST_READY;
      end
      ST_LOAD: begin
        if (!s_reg.reqIssued) begin
          s_next.mediaReq  = 1'b1;
          s_next.reqIssued = 1'b1;
        end else if (mediaTake) begin
          s_next.wordCnt = s_reg.wordCnt + 8'h01;
          if (s_reg.wordCnt == SECTOR_LAST) begin
            if (mediaErr && mediaErrCorr) begin
              s_next.stat.corr = 1'b1;
            end else if (mediaErr) begin
              s_next.stat.err            = 1'b1;
              s_next.errReg[ERR_UNC_BIT] = 1'b1;
              s_next.stopReq             = 1'b1;
            end
            s_next.state = ST_COPY;
          end
        end
      end
      ST_COPY: begin
        if (s_reg.blockStart) begin
          s_next.blockStart = 1'b0;
          if (s_reg.mode != XF_DMA) begin
            s_next.stat.drq   = 1'b1;
            s_next.stat.bsy   = 1'b0;
            s_next.stat.intrq = 1'b1;
          end
        end
        if (push) begin
          s_next.wordCnt = s_reg.wordCnt + 8'h01;
          if (s_reg.wordCnt == SECTOR_LAST) begin
            s_next.secLeft   = s_reg.secLeft - ONE_SECTOR;
            s_next.blkLeft   = s_reg.blkLeft - ONE_SECTOR;
            s_next.reqIssued = 1'b0;
            if (!s_reg.stopReq && s_reg.mode != XF_PIO1) begin
              s_next.tf = next_addr(s_reg.tf, s_reg.spt, s_reg.maxHead);
            end
            if (s_reg.secLeft == ONE_SECTOR || s_reg.blkLeft == ONE_SECTOR ||
                (s_reg.stopReq && s_reg.mode != XF_MULT)) begin
              s_next.state = ST_DRAIN;
            end else begin
              s_next.state = ST_LOAD;
            end
          end
        end
      end
      ST_DRAIN: begin
        if (!fifoOutValid) begin
          s_next.stat.drq = 1'b0;
          if (s_reg.secLeft == '0 || s_reg.stopReq) begin
            s_next.stat.bsy = 1'b0;
            if (s_reg.mode == XF_DMA) begin
              s_next.stat.intrq = 1'b1;
            end
            s_next.state = ST_READY;
          end else begin
            s_next.stat.bsy   = 1'b1;
            s_next.blockStart = 1'b1;
            s_next.blkLeft    = (s_reg.mode != XF_MULT) ? ONE_SECTOR :
                                (blkSz > s_reg.secLeft) ? s_reg.secLeft : blkSz;
            s_next.state      = ST_LOAD;
          end
        end
      end
      default: begin
        s_next.state = ST_READY;
      end
    endcase
    if (s_reg.state != ST_READY && statusRd && !s_next.stat.intrq) begin
      s_next.stat.intrq = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg          <= '0;
      s_reg.state    <= ST_READY;
      s_reg.mode     <= XF_PIO1;
      s_reg.iordPrev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // sector buffer keeps the last loaded sector, flawed or not
  always_ff @(posedge clk) begin
    if (mediaTake) begin
      secBuf[s_reg.wordCnt] <= mediaData;
    end
  end
endmodule : ata_idle_init_read_cmds

// ===== ata_cmd_pkg.sv
// constants, command codes and carrier types for the ata read/idle command block
// assumes a 16-bit data path and a 512-byte sector
package ata_cmd_pkg;

  // command codes
  localparam logic [7:0] CMD_IDLE_IMM_A  = 8'h95;
  localparam logic [7:0] CMD_IDLE_IMM_B  = 8'he1;
  localparam logic [7:0] CMD_INIT_PARAMS = 8'h91;
  localparam logic [7:0] CMD_NOP         = 8'h00;
  localparam logic [7:0] CMD_READ_BUF    = 8'he4;
  localparam logic [7:0] CMD_READ_DMA    = 8'hc8;
  localparam logic [7:0] CMD_READ_MULT   = 8'hc4;

  // sizes
  localparam int         WORD_W        = 16;
  localparam int         FIFO_DEPTH    = 32;
  localparam logic [7:0] SECTOR_LAST   = 8'hff;   // 256 words per sector
  localparam logic [8:0] MAX_SECTORS   = 9'h100;  // count of zero means this
  localparam logic [8:0] ONE_SECTOR    = 9'h001;

  // field positions
  localparam int         ERR_ABRT_BIT  = 2;
  localparam int         ERR_UNC_BIT   = 6;
  localparam int         DH_LBA_BIT    = 6;
  localparam int         HEAD_W        = 4;
  localparam logic [7:0] CHS_FIRST_SEC = 8'h01;

  // command block registers as written by the host
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] sector;
    logic [7:0] cylLow;
    logic [7:0] cylHigh;
    logic [7:0] devHead;
  } taskfile_t;

  // status bits seen by the host
  typedef struct packed {
    logic bsy;
    logic drq;
    logic err;
    logic corr;
    logic intrq;
  } status_t;

  typedef enum logic [5:0] {
    ST_READY = 6'h01,
    ST_POWER = 6'h02,
    ST_LOAD  = 6'h04,
    ST_COPY  = 6'h08,
    ST_DRAIN = 6'h10,
    ST_SPARE = 6'h20
  } state_t;

  typedef enum logic [1:0] {
    XF_PIO1 = 2'h0,
    XF_DMA  = 2'h1,
    XF_MULT = 2'h2
  } xfer_t;

endpackage : ata_cmd_pkg

// ===== ata_cmd_properties.sv
// concurrent checks on the ata command block ports
// assumes one clock domain and host commands only while idle
`timescale 1ns/1ns
module ata_cmd_properties
  import ata_cmd_pkg::*;
(
  input wire logic              clk,             // clock
  input wire logic              rst,             // reset, high
  input wire logic              cmdStrobe,       // command write
  input wire logic [7:0]        cmdCode,         // command code
  input wire taskfile_t         taskIn,          // task file in
  input wire logic              byteModeEn,      // 8-bit mode
  input wire logic              multipleEnabled, // multiple allowed
  input wire logic [7:0]        blockSize,       // block size
  input wire logic              dmarq,           // dma request
  input wire logic              mediaReq,        // sector fetch
  input wire status_t           status,          // status bits
  input wire logic [7:0]        errorReg,        // error bits
  input wire logic              idleMode,        // idle state
  input wire logic [7:0]        sectorsPerTrack, // geometry
  input wire logic [HEAD_W-1:0] maxHead          // heads minus one
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic rdy;
  // a command that the block takes
  assign rdy = cmdStrobe && !status.bsy && !status.drq;
  sequence abort_s;
    status.err && errorReg[ERR_ABRT_BIT] && status.intrq && !status.bsy;
  endsequence
  a_nop_aborts: assert property (rdy && cmdCode == CMD_NOP |=> abort_s)
    else $error("nop not aborted");
  a_idle_sequence: assert property (rdy && (cmdCode == CMD_IDLE_IMM_A ||
    cmdCode == CMD_IDLE_IMM_B) |=> status.bsy ##1 (!status.bsy && status.intrq && idleMode))
    else $error("idle sequence wrong");
  a_dma_byte_abort: assert property (rdy && cmdCode == CMD_READ_DMA && byteModeEn |=> abort_s)
    else $error("dma in byte mode not aborted");
  a_mult_abort: assert property (rdy && cmdCode == CMD_READ_MULT &&
    (!multipleEnabled || blockSize == 8'h00) |=> abort_s)
    else $error("multiple read not aborted");
  a_init_stores: assert property (rdy && cmdCode == CMD_INIT_PARAMS |=>
    sectorsPerTrack == $past(taskIn.count) && maxHead == $past(taskIn.devHead[3:0]))
    else $error("geometry not stored");
  a_read_starts: assert property (rdy && ((cmdCode == CMD_READ_DMA && !byteModeEn) ||
    (cmdCode == CMD_READ_MULT && multipleEnabled && blockSize != 8'h00))
    |=> status.bsy && !mediaReq ##1 mediaReq)
    else $error("read start wrong");
  a_dmarq_busy: assert property (dmarq |-> status.bsy && !status.drq)
    else $error("dmarq outside dma transfer");
  a_irq_not_midway: assert property ($rose(status.intrq) |-> !dmarq)
    else $error("interrupt while dma data waits");
  a_block_irq: assert property ($rose(status.drq) |-> status.intrq && !status.bsy)
    else $error("block start without interrupt");
  c_dma: cover property (rdy && cmdCode == CMD_READ_DMA && !byteModeEn);
  c_block: cover property ($rose(status.drq));
  c_idle: cover property ($rose(idleMode));
endmodule : ata_cmd_properties

bind ata_idle_init_read_cmds ata_cmd_properties i_ata_cmd_properties (.clk, .rst, .cmdStrobe,
  .cmdCode, .taskIn, .byteModeEn, .multipleEnabled, .blockSize, .dmarq, .mediaReq, .status,
  .errorReg, .idleMode, .sectorsPerTrack, .maxHead);

// ===== host_reader.sv
// host side model: dma and pio reader of the data words
// assumes hostData shows a popped word one cycle after the pop
`timescale 1ns/1ns
module host_reader
  import ata_cmd_pkg::*;
(
  input  wire logic              clk,      // clock
  input  wire logic              rst,      // reset, high
  input  wire logic              dmarq,    // dma request
  input  wire logic              drq,      // pio data request
  input  wire logic              slow,     // random stalls
  input  wire logic [WORD_W-1:0] hostData, // word from block
  input  wire logic              popped,   // block handed out a word
  output logic                   dmackN,   // dma acknowledge, low
  output logic                   iordN,    // read strobe, low
  output logic                   hostRd,   // pio read pulse
  output logic                   gotV,     // word received
  output logic      [WORD_W-1:0] gotW      // received word
);
  logic take;
  // one strobe at a time, ack held through it, word taken a cycle later
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dmackN <= 1'b1;
      iordN  <= 1'b1;
      hostRd <= 1'b0;
      take   <= 1'b0;
      gotV   <= 1'b0;
      gotW   <= '0;
    end else begin
      take   <= popped;
      gotV   <= take;
      if (take) gotW <= hostData;
      dmackN <= !dmarq && iordN;
      hostRd <= 1'b0;
      iordN  <= 1'b1;
      if (!(slow && $urandom_range(3) != 0)) begin
        if (dmarq && !dmackN && iordN) iordN <= 1'b0;
        if (drq && !hostRd && !dmarq) hostRd <= 1'b1;
      end
    end
  end
endmodule : host_reader

// ===== ata_idle_init_read_cmds_tb.sv
// self-checking bench for the ata command block
// assumes the host reader model; the bench plays the media source
`timescale 1ns/1ns
module ata_idle_init_read_cmds_tb;
  import ata_cmd_pkg::*;
  logic              clk, rst, cmdStrobe, statusRd, hostRd, dmackN, iordN, dmarq;
  logic              byteModeEn, multipleEnabled, mediaReq, mediaValid, mediaReady;
  logic              mediaErr, mediaErrCorr, idleMode, slow, gotV, corr, drqLast;
  logic [7:0]        cmdCode, blockSize, errorReg, sectorsPerTrack;
  logic [HEAD_W-1:0] maxHead;
  logic [WORD_W-1:0] hostData, mediaData, gotW, seedWord;
  taskfile_t         taskIn, taskOut;
  status_t           status;
  int                fails, check_count, ints, drqs, reqs, served, errAt;
  logic [WORD_W-1:0] expQ[$];

  ata_idle_init_read_cmds i_ata_idle_init_read_cmds (.clk, .rst, .cmdStrobe, .cmdCode,
    .taskIn, .statusRd, .hostRd, .hostData, .dmackN, .iordN, .dmarq, .byteModeEn,
    .multipleEnabled, .blockSize, .mediaReq, .mediaValid, .mediaReady, .mediaData,
    .mediaErr, .mediaErrCorr, .status, .errorReg, .taskOut, .idleMode, .sectorsPerTrack,
    .maxHead);
  host_reader i_host_reader (.clk, .rst, .dmarq, .drq(status.drq), .slow, .hostData,
    .popped(i_ata_idle_init_read_cmds.pop), .dmackN, .iordN, .hostRd, .gotV, .gotW);

  function automatic logic [WORD_W-1:0] expWord(input int s, input int w);
    return {s[7:0] ^ 8'h5a, w[7:0]} ^ seedWord;
  endfunction : expWord
  function automatic logic [27:0] lba(input taskfile_t t);
    return {t.devHead[3:0], t.cylHigh, t.cylLow, t.sector};
  endfunction : lba
  function automatic taskfile_t rndTf();
    logic [63:0] v;
    v = {$urandom, $urandom};
    return v[39:0];
  endfunction : rndTf

  task automatic report_and_stop();
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] code, input taskfile_t tf);
    @(negedge clk);
    cmdCode = code;
    taskIn = tf;
    cmdStrobe = 1'b1;
    @(negedge clk);
    cmdStrobe = 1'b0;
  endtask : cmd
  task automatic waitDone();
    int n;
    n = 0;
    repeat (3) @(negedge clk);
    while ((status.bsy !== 1'b0 || status.drq !== 1'b0 || dmarq !== 1'b0) && n < 40000) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
    chk("finish in time", 1, n < 40000);
  endtask : waitDone
  task automatic runRead(input logic [7:0] code, input int cnt, blk, eAt, input logic c, sl);
    taskfile_t tf;
    int        s0, nSent, nBlk, i0, d0;
    tf = rndTf();
    tf.count = cnt[7:0];
    tf.devHead[DH_LBA_BIT] = 1'b1;
    s0 = served;
    errAt = (eAt < 0) ? -1 : s0 + eAt;
    corr = c;
    slow = sl;
    blockSize = blk[7:0];
    nSent = cnt;
    if (eAt >= 0 && !c) nSent = (code == CMD_READ_MULT) ? (eAt / blk + 1) * blk : eAt + 1;
    if (nSent > cnt) nSent = cnt;
    nBlk = (code == CMD_READ_MULT) ? (nSent + blk - 1) / blk : 1;
    for (int s = 0; s < nSent * 256; s++) expQ.push_back(expWord(s0 + s / 256, s % 256));
    i0 = ints;
    d0 = drqs;
    cmd(code, tf);
    waitDone();
    chk("words left", 0, expQ.size());
    chk("sectors fetched", nSent, served - s0);
    chk("interrupts", nBlk, ints - i0);
    chk("block starts", (code == CMD_READ_MULT) ? nBlk : 0, drqs - d0);
    chk("end address", 28'(lba(tf) + ((eAt >= 0 && !c) ? eAt : cnt)), lba(taskOut));
    chk("uncorrected bit", eAt >= 0 && !c, errorReg[ERR_UNC_BIT]);
    chk("corrected bit", eAt >= 0 && c, status.corr);
  endtask : runRead

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // host interrupt service and block start count
  always @(negedge clk) begin
    statusRd <= (status.intrq === 1'b1) && !statusRd;
    if ((status.intrq === 1'b1) && !statusRd) ints++;
    if ((status.drq === 1'b1) && !drqLast) drqs++;
    drqLast <= status.drq === 1'b1;
  end
  // words reaching the host in order
  always @(negedge clk) begin
    if (gotV === 1'b1 && expQ.size() == 0) begin
      fails++;
      $display("unexpected host word: expected none, seen %h", gotW);
    end else if (gotV === 1'b1) chk("host word", expQ.pop_front(), gotW);
  end
  // media source: one sector per request, random stalls, scrambled when idle
  always @(posedge clk) if (mediaReq === 1'b1) reqs <= reqs + 1;
  initial begin
    mediaValid = 0;
    mediaData = '0;
    mediaErr = 0;
    mediaErrCorr = 0;
    forever begin
      @(negedge clk);
      if (reqs > served) begin
        for (int w = 0; w < 256; w++) begin
          if ($urandom_range(3) == 0) begin
            mediaValid = 0;
            @(negedge clk);
          end
          mediaValid = 1;
          mediaData = expWord(served, w);
          mediaErr = (w == 255) && (served == errAt);
          mediaErrCorr = mediaErr && corr;
          #1;
          while (mediaReady !== 1'b1) begin
            @(negedge clk);
            #1;
          end
          @(negedge clk);
        end
        served++;
        mediaValid = 0;
        mediaData = ~mediaData;
        mediaErr = 0;
        mediaErrCorr = 0;
      end
    end
  end
  // watchdog
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  // main sequence
  initial begin
    logic [7:0] codes [5];
    taskfile_t  tf;
    int         i0;
    codes = '{CMD_NOP, 8'h55, CMD_READ_DMA, CMD_READ_MULT, CMD_READ_MULT};
    void'($urandom(32'hd016691b));
    seedWord = $urandom_range(65535);
    rst = 1;
    {cmdStrobe, statusRd, byteModeEn, slow, corr, cmdCode, blockSize} = '0;
    multipleEnabled = 1;
    taskIn = '0;
    errAt = -1;
    repeat (6) @(negedge clk);
    rst = 0;
    chk("reset status", 0, status);
    chk("reset dmarq", 0, dmarq);
    for (int k = 0; k < 5; k++) begin
      byteModeEn = (k == 2);
      multipleEnabled = (k != 4);
      blockSize = (k == 3) ? 8'h00 : 8'h02;
      i0 = ints;
      cmd(codes[k], rndTf());
      repeat (2) @(negedge clk);
      chk("abort bit", 1, errorReg[ERR_ABRT_BIT]);
      chk("abort irq", i0 + 1, ints);
    end
    byteModeEn = 0;
    multipleEnabled = 1;
    for (int k = 0; k < 2; k++) begin
      i0 = ints;
      cmd(k ? CMD_IDLE_IMM_B : CMD_IDLE_IMM_A, rndTf());
      repeat (3) @(negedge clk);
      chk("idle mode", 1, idleMode);
      chk("idle irq", i0 + 1, ints);
    end
    tf = rndTf();
    cmd(CMD_INIT_PARAMS, tf);
    repeat (2) @(negedge clk);
    chk("sectors per track", tf.count, sectorsPerTrack);
    chk("max head", tf.devHead[3:0], maxHead);
    runRead(CMD_READ_DMA, 3, 2, -1, 0, 1);
    runRead(CMD_READ_DMA, 3, 2, 1, 0, 0);
    for (int w = 0; w < 256; w++) expQ.push_back(expWord(served - 1, w));
    tf = taskOut;
    i0 = ints;
    cmd(CMD_READ_BUF, rndTf());
    waitDone();
    chk("buffer words", 0, expQ.size());
    chk("buffer irq", i0 + 1, ints);
    chk("buffer address", lba(tf), lba(taskOut));
    runRead(CMD_READ_MULT, 5, 2, -1, 0, 1);
    runRead(CMD_READ_MULT, 5, 2, 2, 0, 0);
    runRead(CMD_READ_MULT, 4, 3, 0, 1, 0);
    runRead(CMD_READ_DMA, 2, 1, 1, 1, 0);
    for (int r = 0; r < 4; r++)
      runRead(r[0] ? CMD_READ_MULT : CMD_READ_DMA, $urandom_range(4, 1), $urandom_range(3, 1),
              -1, 0, r[1]);
    report_and_stop();
  end
endmodule : ata_idle_init_read_cmds_tb
